// >>> hw/irfs_top.sv
// region-of-interest crop, mirror, pixel packing and compression stage
// assumes a sensor readout that returns a pixel one cycle after its address,
// a downstream packetiser that accepts every output beat, one clock mclk
//
// Summary of operation
// - crop geometry can only be written while acquisition is stopped and idle.
// - there is one crop region; the region selector reads zero and holds only index zero.
// - column and row origin give the upper-left pixel of the crop in the sensor frame.
// - after reset the crop spans the full maximum width and height at origin zero.
// - horizontal mirror reverses column order per line, vertical mirror reverses line order.
// - maximum column and row counts are readable registers.
// - packed 10 and 12 bit mono or bayer encodings emit 12 bits per pixel.
// - unpacked 10/12 bit encodings and the two 4:2:2 encodings emit 16 bits per pixel.
// - reset selects mono 8 or bayer 8 by device type; mono 8 and bayer 8 emit 8 bits per pixel.
// - with compression on, burst mode drops the inter-frame gap to raise the frame rate.
// - a readable counter steps for every compressed frame larger than its raw size.
// - a readable revision value names the compression function version.
`timescale 1ns/100ps
`include "irfs_params.svh"
module irfs_top #(
  parameter logic [15:0] WIDTH_MAX = 16'h0990,
  parameter logic [15:0] HEIGHT_MAX = 16'h0800,
  parameter bit COLOR = 1'b0,
  parameter logic [31:0] COMP_REV = 32'h0000_0001 // value is arbitrary
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // sensor readout port
  output logic pix_req,
  output logic [15:0] pix_col,
  output logic [15:0] pix_row,
  input wire logic [11:0] pix_data,
  // pixel stream out
  output logic out_valid,
  output logic [24:0] out_data,
  output logic [4:0] out_bits,
  output logic out_sof,
  output logic out_eol,
  output logic out_eof,
  // status
  output logic acq_active
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // output width of one pixel for an encoding
  function automatic logic [4:0] irfs_bpp(input logic [3:0] f);
    case (f)
      `IRFS_FMT_MONO8, `IRFS_FMT_BAYER8: return `IRFS_BPP8;
      `IRFS_FMT_MONO10P, `IRFS_FMT_MONO12P,
      `IRFS_FMT_BAYER10P, `IRFS_FMT_BAYER12P: return `IRFS_BPP12;
      `IRFS_FMT_MONO10, `IRFS_FMT_MONO12, `IRFS_FMT_BAYER10,
      `IRFS_FMT_BAYER12, `IRFS_FMT_YUV422, `IRFS_FMT_YUYV: return `IRFS_BPP16;
      `IRFS_FMT_RGB8, `IRFS_FMT_BGR8: return `IRFS_BPP24;
      default: return `IRFS_BPP8;
    endcase
  endfunction : irfs_bpp

  // place one sensor sample into its encoding, low bits first
  function automatic logic [23:0] irfs_pack(input logic [3:0] f, input logic [11:0] p);
    case (f)
      `IRFS_FMT_MONO8, `IRFS_FMT_BAYER8: return {16'h0000, p[11:4]};
      `IRFS_FMT_MONO10P, `IRFS_FMT_BAYER10P: return {14'h0000, p[11:2]};
      `IRFS_FMT_MONO12P, `IRFS_FMT_BAYER12P: return {12'h000, p};
      `IRFS_FMT_MONO10, `IRFS_FMT_BAYER10: return {14'h0000, p[11:2]};
      `IRFS_FMT_MONO12, `IRFS_FMT_BAYER12: return {12'h000, p};
      // no chroma source here, so chroma stays neutral
      `IRFS_FMT_YUV422, `IRFS_FMT_YUYV: return {8'h00, 8'h80, p[11:4]};
      // no demosaic in this stage: grey replicated to all channels
      `IRFS_FMT_RGB8, `IRFS_FMT_BGR8: return {p[11:4], p[11:4], p[11:4]};
      default: return {16'h0000, p[11:4]};
    endcase
  endfunction : irfs_pack

  // encoding is one this stage knows
  function automatic logic irfs_fmt_ok(input logic [3:0] f);
    return f <= `IRFS_FMT_BGR8;
  endfunction : irfs_fmt_ok

  ////////////////////////////////////////////////////////////////////////////
  // state

  irfs_pkg::irfs_regs_t q;
  irfs_pkg::irfs_regs_t next_q;

  logic active;
  logic last_col;
  logic last_row;
  logic same_pix;
  logic [4:0] bpp;
  logic [23:0] packed_pix;
  logic [4:0] tok_bits;
  logic [24:0] tok_data;
  logic [31:0] raw_sum;
  logic [31:0] comp_sum;

  // geometry is frozen while a frame runs or acquisition is armed
  assign active = q.acq | (q.st != irfs_pkg::IRFS_IDLE);
  assign last_col = (q.col == q.w - 16'h0001);
  assign last_row = (q.row == q.h - 16'h0001);

  ////////////////////////////////////////////////////////////////////////////
  // readout addressing

  // raster walk of the crop, mirrored into sensor coordinates
  assign pix_req = (q.st == irfs_pkg::IRFS_RUN);
  assign pix_col = q.rev_x ? 16'(q.ox + q.w - 16'h0001 - q.col)
                           : 16'(q.ox + q.col);
  assign pix_row = q.rev_y ? 16'(q.oy + q.h - 16'h0001 - q.row)
                           : 16'(q.oy + q.row);

  ////////////////////////////////////////////////////////////////////////////
  // formatting and compression terms for the pixel now returning

  // a repeat of the previous pixel in a line costs one flag bit
  assign bpp = irfs_bpp(q.fmt);
  assign packed_pix = irfs_pack(q.fmt, pix_data);
  assign same_pix = !q.p_sol && (pix_data == q.prev);
  assign tok_bits = same_pix ? 5'h01 : 5'(bpp + 5'h01);
  assign tok_data = same_pix ? 25'h0000000 : ({1'b0, packed_pix} | (25'h0000001 << bpp));
  assign raw_sum = (q.p_sof ? 32'h00000000 : q.raw_bits) + {27'h0000000, bpp};
  assign comp_sum = (q.p_sof ? 32'h00000000 : q.comp_bits) + {27'h0000000, tok_bits};

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_q = q;
    next_q.rdata = 32'h00000000;

    // register reads, answered in the next cycle
    if (reg_rd) begin
      case (reg_addr)
        `IRFS_ADDR_CTRL: begin
          next_q.rdata[`IRFS_CTRL_ACQ] = q.acq;
          next_q.rdata[`IRFS_CTRL_REVX] = q.rev_x;
          next_q.rdata[`IRFS_CTRL_REVY] = q.rev_y;
          next_q.rdata[`IRFS_CTRL_COMP] = q.comp;
          next_q.rdata[`IRFS_CTRL_BURST] = q.burst;
        end
        `IRFS_ADDR_FMT: next_q.rdata = {28'h0000000, q.fmt};
        `IRFS_ADDR_WIDTH: next_q.rdata = {16'h0000, q.w};
        `IRFS_ADDR_HEIGHT: next_q.rdata = {16'h0000, q.h};
        `IRFS_ADDR_OFFX: next_q.rdata = {16'h0000, q.ox};
        `IRFS_ADDR_OFFY: next_q.rdata = {16'h0000, q.oy};
        `IRFS_ADDR_REGSEL: next_q.rdata = 32'h00000000;
        `IRFS_ADDR_WMAX: next_q.rdata = {16'h0000, WIDTH_MAX};
        `IRFS_ADDR_HMAX: next_q.rdata = {16'h0000, HEIGHT_MAX};
        `IRFS_ADDR_OVF: next_q.rdata = q.ovf;
        `IRFS_ADDR_REV: next_q.rdata = COMP_REV;
        `IRFS_ADDR_STAT: next_q.rdata = {29'h00000000, active, q.st};
        default: next_q.rdata = 32'h00000000;
      endcase
    end

    // register writes; all settings but the run bit are dropped unless idle
    if (reg_wr) begin
      case (reg_addr)
        `IRFS_ADDR_CTRL: begin
          next_q.acq = reg_wdata[`IRFS_CTRL_ACQ];
          if (!active) begin
            next_q.rev_x = reg_wdata[`IRFS_CTRL_REVX];
            next_q.rev_y = reg_wdata[`IRFS_CTRL_REVY];
            next_q.comp = reg_wdata[`IRFS_CTRL_COMP];
            next_q.burst = reg_wdata[`IRFS_CTRL_BURST];
          end
        end
        `IRFS_ADDR_FMT: begin
          if (!active && irfs_fmt_ok(reg_wdata[3:0])) begin
            next_q.fmt = reg_wdata[3:0];
          end
        end
        // a zero size would stall the walk, so it is refused
        `IRFS_ADDR_WIDTH: begin
          if (!active && (reg_wdata[15:0] != 16'h0000)) begin
            next_q.w = reg_wdata[15:0];
          end
        end
        `IRFS_ADDR_HEIGHT: begin
          if (!active && (reg_wdata[15:0] != 16'h0000)) begin
            next_q.h = reg_wdata[15:0];
          end
        end
        `IRFS_ADDR_OFFX: begin
          if (!active) begin
            next_q.ox = reg_wdata[15:0];
          end
        end
        `IRFS_ADDR_OFFY: begin
          if (!active) begin
            next_q.oy = reg_wdata[15:0];
          end
        end
        default: begin
        end
      endcase
    end

    // frame sequencer
    next_q.p_valid = 1'b0;
    next_q.p_sof = 1'b0;
    next_q.p_sol = 1'b0;
    next_q.p_eol = 1'b0;
    next_q.p_eof = 1'b0;
    case (q.st)
      irfs_pkg::IRFS_IDLE: begin
        next_q.col = 16'h0000;
        next_q.row = 16'h0000;
        if (q.acq) begin
          next_q.st = irfs_pkg::IRFS_RUN;
        end
      end
      irfs_pkg::IRFS_RUN: begin
        // tags travel with the request to meet its returning pixel
        next_q.p_valid = 1'b1;
        next_q.p_sof = (q.col == 16'h0000) && (q.row == 16'h0000);
        next_q.p_sol = (q.col == 16'h0000);
        next_q.p_eol = last_col;
        next_q.p_eof = last_col && last_row;
        if (!last_col) begin
          next_q.col = 16'(q.col + 16'h0001);
        end else begin
          next_q.col = 16'h0000;
          next_q.row = 16'(q.row + 16'h0001);
          if (last_row) begin
            next_q.row = 16'h0000;
            // burst with compression on skips the idle gap between frames
            if (q.comp && q.burst) begin
              next_q.st = q.acq ? irfs_pkg::IRFS_RUN : irfs_pkg::IRFS_IDLE;
            end else begin
              next_q.st = irfs_pkg::IRFS_GAP;
              next_q.gap = `IRFS_FRAME_GAP;
            end
          end
        end
      end
      irfs_pkg::IRFS_GAP: begin
        next_q.gap = 16'(q.gap - 16'h0001);
        if (q.gap == 16'h0001) begin
          next_q.st = q.acq ? irfs_pkg::IRFS_RUN : irfs_pkg::IRFS_IDLE;
        end
      end
      default: begin
        next_q.st = irfs_pkg::IRFS_IDLE;
      end
    endcase

    // output stage: pixel arrives one cycle after its request
    next_q.o_valid = q.p_valid;
    next_q.o_sof = q.p_valid & q.p_sof;
    next_q.o_eol = q.p_valid & q.p_eol;
    next_q.o_eof = q.p_valid & q.p_eof;
    if (q.p_valid) begin
      next_q.prev = pix_data;
      next_q.raw_bits = raw_sum;
      next_q.comp_bits = comp_sum;
      if (q.comp) begin
        next_q.o_data = tok_data;
        next_q.o_bits = tok_bits;
      end else begin
        next_q.o_data = {1'b0, packed_pix};
        next_q.o_bits = bpp;
      end
      // a frame that grew under compression is counted
      if (q.p_eof && q.comp && (comp_sum > raw_sum)) begin
        next_q.ovf = q.ovf + 32'h00000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // reset gives full frame, mono 8 or bayer 8, all options off
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
      q.st <= irfs_pkg::IRFS_IDLE;
      q.w <= WIDTH_MAX;
      q.h <= HEIGHT_MAX;
      q.fmt <= COLOR ? `IRFS_FMT_BAYER8 : `IRFS_FMT_MONO8;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata = q.rdata;
  assign out_valid = q.o_valid;
  assign out_data = q.o_data;
  assign out_bits = q.o_bits;
  assign out_sof = q.o_sof;
  assign out_eol = q.o_eol;
  assign out_eof = q.o_eof;
  assign acq_active = active;

endmodule : irfs_top

// >>> hw/irfs_params.svh
// constants of the region-of-interest and pixel format stage
// assumes inclusion by the package and the top module only
`ifndef IRFS_PARAMS_SVH
`define IRFS_PARAMS_SVH
// field widths
`define IRFS_DIM_W 16
`define IRFS_PIX_W 12
`define IRFS_OUT_W 25
`define IRFS_BITS_W 5
// register offsets (byte addresses)
`define IRFS_ADDR_CTRL 8'h00
`define IRFS_ADDR_FMT 8'h04
`define IRFS_ADDR_WIDTH 8'h08
`define IRFS_ADDR_HEIGHT 8'h0c
`define IRFS_ADDR_OFFX 8'h10
`define IRFS_ADDR_OFFY 8'h14
`define IRFS_ADDR_REGSEL 8'h18
`define IRFS_ADDR_WMAX 8'h1c
`define IRFS_ADDR_HMAX 8'h20
`define IRFS_ADDR_OVF 8'h24
`define IRFS_ADDR_REV 8'h28
`define IRFS_ADDR_STAT 8'h2c
// control bit positions
`define IRFS_CTRL_ACQ 0
`define IRFS_CTRL_REVX 1
`define IRFS_CTRL_REVY 2
`define IRFS_CTRL_COMP 3
`define IRFS_CTRL_BURST 4
// pixel encodings
`define IRFS_FMT_MONO8 4'h0
`define IRFS_FMT_BAYER8 4'h1
`define IRFS_FMT_MONO10P 4'h2
`define IRFS_FMT_MONO12P 4'h3
`define IRFS_FMT_BAYER10P 4'h4
`define IRFS_FMT_BAYER12P 4'h5
`define IRFS_FMT_MONO10 4'h6
`define IRFS_FMT_MONO12 4'h7
`define IRFS_FMT_BAYER10 4'h8
`define IRFS_FMT_BAYER12 4'h9
`define IRFS_FMT_YUV422 4'ha
`define IRFS_FMT_YUYV 4'hb
`define IRFS_FMT_RGB8 4'hc
`define IRFS_FMT_BGR8 4'hd
// bits per pixel
`define IRFS_BPP8 5'h08
`define IRFS_BPP12 5'h0c
`define IRFS_BPP16 5'h10
`define IRFS_BPP24 5'h18
// idle cycles between frames unless burst with compression on
`define IRFS_FRAME_GAP 16'h0100
`endif

// >>> hw/irfs_pkg.sv
// types of the region-of-interest and pixel format stage
// assumes irfs_params.svh on the include path
`include "irfs_params.svh"
package irfs_pkg;
  typedef enum logic [1:0] {
    IRFS_IDLE = 2'b00,
    IRFS_RUN = 2'b01,
    IRFS_GAP = 2'b10
  } irfs_state_t;

  typedef struct packed {
    irfs_state_t st;
    logic acq;
    logic rev_x;
    logic rev_y;
    logic comp;
    logic burst;
    logic [3:0] fmt;
    logic [`IRFS_DIM_W-1:0] w;
    logic [`IRFS_DIM_W-1:0] h;
    logic [`IRFS_DIM_W-1:0] ox;
    logic [`IRFS_DIM_W-1:0] oy;
    logic [`IRFS_DIM_W-1:0] col;
    logic [`IRFS_DIM_W-1:0] row;
    logic [`IRFS_DIM_W-1:0] gap;
    logic p_valid;
    logic p_sof;
    logic p_sol;
    logic p_eol;
    logic p_eof;
    logic o_valid;
    logic o_sof;
    logic o_eol;
    logic o_eof;
    logic [`IRFS_OUT_W-1:0] o_data;
    logic [`IRFS_BITS_W-1:0] o_bits;
    logic [`IRFS_PIX_W-1:0] prev;
    logic [31:0] raw_bits;
    logic [31:0] comp_bits;
    logic [31:0] ovf;
    logic [31:0] rdata;
  } irfs_regs_t;
endpackage : irfs_pkg

// >>> tb/irfs_top_checker.sv
// checker of the crop and pixel format stage
// assumes a bind onto irfs_top with its parameters handed on
`timescale 1ns/100ps
module irfs_top_checker #(
  parameter logic [15:0] WIDTH_MAX = 16'h0990,
  parameter logic [15:0] HEIGHT_MAX = 16'h0800,
  parameter logic [31:0] COMP_REV = 32'h0000_0001 // value is arbitrary
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // readout and stream
  input wire logic pix_req,
  input wire logic out_valid,
  input wire logic [4:0] out_bits,
  input wire logic out_sof,
  input wire logic out_eol,
  input wire logic out_eof
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // fixed values answer one cycle after the read strobe
  property p_wmax;
    reg_rd && reg_addr == 8'h1c |=> reg_rdata == {16'h0000, WIDTH_MAX};
  endproperty
  a_wmax: assert property (p_wmax) else $error("bad width max");
  property p_hmax;
    reg_rd && reg_addr == 8'h20 |=> reg_rdata == {16'h0000, HEIGHT_MAX};
  endproperty
  a_hmax: assert property (p_hmax) else $error("bad height max");
  property p_regsel;
    reg_rd && reg_addr == 8'h18 |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_regsel: assert property (p_regsel) else $error("region index not zero");
  property p_rev;
    reg_rd && reg_addr == 8'h28 |=> reg_rdata == COMP_REV;
  endproperty
  a_rev: assert property (p_rev) else $error("bad revision");
  ////////////////////////////////////////
  // no back-pressure, so every request must leave two cycles on
  property p_lat;
    pix_req |-> ##2 out_valid;
  endproperty
  a_lat: assert property (p_lat) else $error("request lost");
  property p_sof;
    $rose(pix_req) |-> ##2 (out_valid && out_sof);
  endproperty
  a_sof: assert property (p_sof) else $error("frame start missing");
  property p_eof;
    out_eof |-> out_valid && out_eol;
  endproperty
  a_eof: assert property (p_eof) else $error("frame end off a line end");
  // raw sizes and token sizes only
  property p_bits;
    out_valid |-> out_bits inside {5'h01, 5'h08, 5'h09, 5'h0c, 5'h0d, 5'h10, 5'h11, 5'h18, 5'h19};
  endproperty
  a_bits: assert property (p_bits) else $error("bad pixel size");
  c_frame: cover property (out_eof);
  c_repeat: cover property (out_valid && out_bits == 5'h01);
  c_ovf: cover property (reg_rd && reg_addr == 8'h24);
endmodule : irfs_top_checker

bind irfs_top irfs_top_checker #(.WIDTH_MAX(WIDTH_MAX), .HEIGHT_MAX(HEIGHT_MAX), .COMP_REV(COMP_REV)) u_chk (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_req(pix_req),
  .out_valid(out_valid), .out_bits(out_bits), .out_sof(out_sof), .out_eol(out_eol), .out_eof(out_eof));

// >>> tb/irfs_sensor_model.sv
// sensor readout model answering one cycle after each request
// assumes the stage's request port on the same clock
`timescale 1ns/100ps
module irfs_sensor_model (
  // clock
  input wire logic mclk,
  // request and answer
  input wire logic pix_req,
  input wire logic [15:0] pix_col,
  input wire logic [15:0] pix_row,
  input wire logic flat,
  output logic [11:0] pix_data
);
  initial pix_data = 12'h000;
  // sample tells its place, or is constant when flat;
  // between requests the line flips so stale data is never reused
  always @(posedge mclk) begin
    if (pix_req)
      pix_data <= flat ? 12'h5a5 : {pix_row[3:0], pix_col[7:0]};
    else
      pix_data <= ~pix_data;
  end
endmodule : irfs_sensor_model

// >>> tb/tb.sv
// self-checking bench of the crop and pixel format stage
// assumes irfs_top, the sensor model and the bound checker
`timescale 1ns/100ps
module tb;
  logic mclk, rst, reg_wr, reg_rd, pix_req, out_valid, out_sof, out_eol, out_eof, acq_active, flat;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic [15:0] pix_col, pix_row;
  logic [11:0] pix_data;
  logic [24:0] out_data;
  logic [4:0] out_bits;
  logic [31:0] reqs[$];
  logic [7:0] beats[$];
  logic [24:0] datas[$];
  int n_mismatch = 0;
  int cmp_count = 0;
  ////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // small sensor keeps full frames short
  irfs_top #(.WIDTH_MAX(16'h0008), .HEIGHT_MAX(16'h0004), .COLOR(1'b0), .COMP_REV(32'h0000_0001)) dut (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pix_req(pix_req), .pix_col(pix_col), .pix_row(pix_row), .pix_data(pix_data),
    .out_valid(out_valid), .out_data(out_data), .out_bits(out_bits), .out_sof(out_sof), .out_eol(out_eol),
    .out_eof(out_eof), .acq_active(acq_active));
  irfs_sensor_model u_sens (.mclk(mclk), .pix_req(pix_req), .pix_col(pix_col), .pix_row(pix_row), .flat(flat),
    .pix_data(pix_data));
  // log requests and beats as the stage makes them
  always @(posedge mclk) begin
    if (pix_req === 1'b1)
      reqs.push_back({pix_row, pix_col});
    if (out_valid === 1'b1) begin
      beats.push_back({out_sof, out_eol, out_eof, out_bits});
      datas.push_back(out_data);
    end
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd
  task automatic wait_idle();
    int k;
    for (k = 0; k < 3000 && acq_active !== 1'b0; k++)
      @(posedge mclk);
    if (k == 3000) begin
      check(acq_active, 1'b0, "idle wait");
      report_and_stop();
    end
  endtask : wait_idle
  // one frame with the given crop and control bits; run bit cleared at once
  task automatic run_frame(input int ox, input int oy, input int w, input int h, input logic [4:0] ctl);
    int i;
    int c;
    int r;
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h08, w);
    wr(8'h0c, h);
    wr(8'h10, ox);
    wr(8'h14, oy);
    reqs.delete();
    beats.delete();
    datas.delete();
    wr(8'h00, {27'h0, ctl | 5'h01});
    wr(8'h00, {27'h0, ctl & 5'h1e});
    wait_idle();
    check(reqs.size(), w * h, "request count");
    check(beats.size(), w * h, "beat count");
    for (i = 0; i < reqs.size(); i++) begin
      c = ctl[1] ? ox + w - 1 - i % w : ox + i % w;
      r = ctl[2] ? oy + h - 1 - i / w : oy + i / w;
      check(reqs[i], {r[15:0], c[15:0]}, "request place");
      check(beats[i][7:5], {i == 0, i % w == w - 1, i == w * h - 1}, "beat flags");
    end
  endtask : run_frame
  ////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] adr[12] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h04, 8'h00, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h30};
    logic [31:0] exv[12] = '{8, 4, 0, 0, 0, 0, 0, 8, 4, 0, 1, 0};
    wr(8'h18, 32'h1);
    wr(8'h30, 32'h5);
    foreach (adr[i]) begin
      rd(adr[i]);
      check(rd_val, exv[i], "reset value");
    end
    $display("reset test done");
  endtask : t_reset
  task automatic t_crop();
    run_frame(0, 0, 8, 4, 5'h00);
    for (int m = 0; m < 4; m++)
      run_frame(2, 1, 3, 2, 5'(m * 2));
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h5);
    wr(8'h00, 32'h0);
    wait_idle();
    rd(8'h08);
    check(rd_val, 32'h3, "width frozen");
    $display("crop test done");
  endtask : t_crop
  task automatic t_formats();
    // flat sample 5a5 packed low-aligned per encoding
    logic [23:0] exd[14] = '{24'h00005a, 24'h00005a, 24'h000169, 24'h0005a5, 24'h000169, 24'h0005a5, 24'h000169,
      24'h0005a5, 24'h000169, 24'h0005a5, 24'h00805a, 24'h00805a, 24'h5a5a5a, 24'h5a5a5a};
    flat <= 1'b1;
    for (int f = 0; f < 14; f++) begin
      wr(8'h04, f);
      run_frame(0, 0, 1, 1, 5'h00);
      check(beats[0][4:0], f < 2 ? 8 : f < 6 ? 12 : f < 12 ? 16 : 24, "pixel size");
      check(datas[0], {8'h00, exd[f]}, "pixel data");
    end
    flat <= 1'b0;
    wr(8'h04, 32'h0);
    $display("format test done");
  endtask : t_formats
  task automatic t_comp();
    logic [31:0] ov;
    int k;
    int g;
    rd(8'h24);
    ov = rd_val;
    for (int fl = 1; fl >= 0; fl--) begin
      flat <= fl[0];
      run_frame(0, 0, 8, 4, 5'h08);
      for (k = 1; k < 32; k++)
        check(beats[k][4:0], (fl && (k % 8 != 0)) ? 1 : 9, "token size");
      rd(8'h24);
      check(rd_val, ov + 1 - fl, "overflow count");
    end
    // burst must shorten the idle stretch between frames
    for (int b = 0; b < 2; b++) begin
      wr(8'h00, {27'h0, b[0], 4'h9});
      for (k = 0; k < 600 && pix_req !== 1'b1; k++)
        @(posedge mclk);
      for (; k < 600 && pix_req !== 1'b0; k++)
        @(posedge mclk);
      for (g = 0; k < 600 && pix_req !== 1'b1; k++, g++)
        @(posedge mclk);
      wr(8'h00, {27'h0, b[0], 4'h8});
      wait_idle();
      check(g >= 256, b == 0, "frame gap");
    end
    $display("compression test done");
  endtask : t_comp
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    flat = 1'b0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_crop();
    t_formats();
    t_comp();
    report_and_stop();
  end
endmodule : tb
